/* File: bsc_pkg.sv */
// Purpose: Shared constants and types for the boost set-point control
// Assumes: 20 MHz system clock
// Notes: Register offsets are byte pointers on the I2C register interface
`default_nettype none
package bsc_pkg;

  // Arbitrary 7-bit bus address, not tied to any part
  localparam logic [6:0] DEV_ADDR = 7'h2a;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_VCODE = 8'h00;
  localparam logic [7:0] REG_ICODE = 8'h01;
  localparam logic [7:0] REG_CTRL = 8'h02;
  localparam logic [7:0] REG_FAULT = 8'h03;

  // Field positions
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_UV_UNMASK_BIT = 1;
  localparam int CTRL_OV_UNMASK_BIT = 2;
  localparam int FLT_UV_BIT = 0;
  localparam int FLT_OV_BIT = 1;
  localparam int CFG_SEQ_DEP_BIT = 0;
  localparam int CFG_ILIM_HI_BIT = 1;

  // Reset values
  localparam logic [5:0] VCODE_RST = 6'h1c;
  localparam logic [5:0] ICODE_RST = 6'h00;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // ----------------------------------------------------------------
  // Set-point arithmetic
  // ----------------------------------------------------------------
  localparam logic [14:0] VBASE_MV = 15'h1388;
  localparam logic [14:0] VSTEP_MV = 15'h00fa;
  localparam logic [14:0] VGROUP_MV = 15'h07d0;
  localparam logic [17:0] PG_NUM = 18'h00007;
  localparam logic [17:0] PG_DEN = 18'h0000a;
  localparam logic [15:0] ISTEP_UA = 16'h0271;
  localparam logic [15:0] ISINK_MAX_UA = 16'h99cf;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 20000000;
  localparam int unsigned SS_TIME_MS = 80;
  localparam int unsigned SS_CYCLES = SS_TIME_MS * (SYS_CLK_HZ / 1000);

  // Bus engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } bsc_bus_st_t;

endpackage
`default_nettype wire

/* File: bsc_sp_if.sv */
// Purpose: Carries settings and set-point results between control and set-point
// Assumes: Single clock domain
// Notes: Every signal is a flop output on its driving side
`timescale 1ns/100ps
`default_nettype none
interface bsc_sp_if;
  logic on;
  logic [5:0] vcode;
  logic [14:0] target_mv;
  logic [14:0] pg_mv;
  logic ss_active;
  modport ctl(output on, output vcode, input target_mv, input pg_mv, input ss_active);
  modport sp(input on, input vcode, output target_mv, output pg_mv, output ss_active);
endinterface
`default_nettype wire

/* File: bsc_setpoint.sv */
// Purpose: Voltage target, power-good threshold and soft-start timer
// Assumes: Code and on bit come from flops of the control block
// Notes: Target follows the code directly; only enable starts a ramp
`timescale 1ns/100ps
`default_nettype none
module bsc_setpoint #(
  parameter int unsigned SS_CYCLES = bsc_pkg::SS_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Settings in, results out
  bsc_sp_if.sp sp
);

  typedef struct packed {
    logic [14:0] target_mv;
    logic [14:0] pg_mv;
    logic [20:0] ss_cnt;
    logic ss_active;
    logic on_d;
  } bsc_sp_st_t;

  bsc_sp_st_t q;
  bsc_sp_st_t n;

  // Millivolt target from code: base plus code times step
  function automatic logic [14:0] vtarget(input logic [5:0] code);
    vtarget = bsc_pkg::VBASE_MV + bsc_pkg::VSTEP_MV * {9'h000, code};
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [17:0] prod;
    prod = 18'h00000;
    n = q;
    n.on_d = sp.on;
    n.target_mv = vtarget(sp.vcode);
    prod = {3'h0, n.target_mv} * bsc_pkg::PG_NUM;
    n.pg_mv = 15'(prod / bsc_pkg::PG_DEN);
    // Ramp restarts on each enable edge and is cut short by disable
    if (sp.on && !q.on_d) begin
      n.ss_active = 1'b1;
      n.ss_cnt = 21'h000000;
    end else if (!sp.on) begin
      n.ss_active = 1'b0;
    end else if (q.ss_active) begin
      if (q.ss_cnt == 21'(SS_CYCLES - 1)) begin
        n.ss_active = 1'b0;
      end else begin
        n.ss_cnt = q.ss_cnt + 21'h000001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign sp.target_mv = q.target_mv;
  assign sp.pg_mv = q.pg_mv;
  assign sp.ss_active = q.ss_active;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  vtarget_val_a: assert property (
    $past(i_rst_n) |-> q.target_mv == 15'd5000 + 15'd250 * {9'h000, $past(sp.vcode)})
    else $error("voltage target does not match code");
  vgroup_val_a: assert property (
    $past(i_rst_n) |-> q.target_mv == 15'd5000 + 15'd2000 * {12'h000, $past(sp.vcode[5:3])}
      + 15'd250 * {12'h000, $past(sp.vcode[2:0])})
    else $error("voltage group and step do not add up");
  ss_start_a: assert property ($rose(sp.on) |=> ##1 q.ss_active)
    else $error("soft start did not begin on enable");

endmodule
`default_nettype wire

/* File: bsc_top.sv */
// Purpose: Boost set-point, current sink and fault interrupt control
// Assumes: I2C pins, comparators and straps are asynchronous to I_SYS_CLK
// Notes: SDA is open drain; O_SDA_OE high pulls the line low
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Output target is 5 V plus voltage code times 0.25 V.
// - Target spans 5 to 20.75 V; high bits 2 V groups, low bits 250 mV.
// - Sink current equals sink code times 0.625 mA.
// - Sink current never exceeds 39.375 mA.
// - Sink is off for code zero, on for any non-zero code.
// - Converter on bit and sink work independently.
// - Disable reaches downstream trigger only when factory config asks.
// - New voltage code becomes the target at once, no ramp.
// - Internal power good above 70 percent of target, not host readable.
// - Separate undervoltage and overvoltage status bits for the host.
// - Masked fault bits show the live condition.
// - Unmasked fault drives the active low interrupt.
// - Interrupt holds until fault read and converter off or regulating.
// - Reading clears a latched fault only if no longer present.
// - Large voltage steps while enabled may trip fault detection.
// - Peak switch limit is a factory choice the host cannot change.
// - Enabling starts a fixed 80 ms soft-start ramp.
module bsc_top #(
  parameter int unsigned SS_CYCLES = bsc_pkg::SS_CYCLES
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // I2C register interface
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA_O,
  output logic O_SDA_OE,
  // Analog comparators and factory straps
  input wire logic I_UV_DET,
  input wire logic I_OV_DET,
  input wire logic I_PG_CMP,
  input wire logic [1:0] I_FACTORY_CONFIG_IMAGE,
  // Converter controls
  output logic O_BOOST_EN,
  output logic O_SS_ACTIVE,
  output logic [14:0] O_VTARGET_MV,
  output logic [14:0] O_PG_THRESH_MV,
  output logic O_ILIM_HI,
  // Current sink
  output logic O_SINK_EN,
  output logic [15:0] O_SINK_UA,
  // Sequencing and host interrupt
  output logic O_POWER_GOOD_INTERNAL,
  output logic O_SEQ_TRIG,
  output logic O_INTERRUPT_REQUEST_N
);

  typedef struct packed {
    logic [2:0] scl, sda;
    logic [1:0] uv, ov, pg;
    logic [1:0] cfg_s1, cfg_s2, cfg_cap, cap_cnt;
    bsc_pkg::bsc_bus_st_t st;
    logic [3:0] bitcnt;
    logic [1:0] idx;
    logic rw, more;
    logic [7:0] shift, ptr;
    logic sda_oe;
    logic [5:0] vcode, icode;
    logic [2:0] ctrl;
    logic [1:0] lat, rd_seen, pend;
    logic irq_n, sink_en;
    logic [15:0] sink_ua;
    logic pg_int, seq_trig;
  } bsc_top_st_t;

  localparam bsc_top_st_t ST_RST = '{
    scl: 3'h7,
    sda: 3'h7,
    st: bsc_pkg::ST_IDLE,
    vcode: bsc_pkg::VCODE_RST,
    icode: bsc_pkg::ICODE_RST,
    ctrl: bsc_pkg::CTRL_RST,
    irq_n: 1'b1,
    default: '0
  };
  bsc_top_st_t q;
  bsc_top_st_t n;
  bsc_sp_if sp_if ();
  logic scl_rise, scl_fall, bus_start, bus_stop, conv_on;
  logic [1:0] unmask, live;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Masked bits show the live level, unmasked ones the latch
  function automatic logic [1:0] flt_view(input logic [1:0] lat,
                                          input logic [1:0] lv,
                                          input logic [1:0] um);
    flt_view = (lat & um) | (lv & ~um);
  endfunction

  // Read data for a register pointer; unmapped pointers read zero
  function automatic logic [7:0] reg_read(input bsc_top_st_t s,
                                          input logic [1:0] lv);
    reg_read = 8'h00;
    if (s.ptr == bsc_pkg::REG_VCODE) begin
      reg_read = {2'h0, s.vcode};
    end else if (s.ptr == bsc_pkg::REG_ICODE) begin
      reg_read = {2'h0, s.icode};
    end else if (s.ptr == bsc_pkg::REG_CTRL) begin
      reg_read = {5'h00, s.ctrl};
    end else if (s.ptr == bsc_pkg::REG_FAULT) begin
      reg_read = {6'h00, flt_view(s.lat, lv, s.ctrl[2:1])};
    end
  endfunction

  // Sink current in microamps, held at the ceiling
  function automatic logic [15:0] sink_ua(input logic [5:0] code);
    logic [15:0] raw;
    raw = {10'h000, code} * bsc_pkg::ISTEP_UA;
    sink_ua = (raw > bsc_pkg::ISINK_MAX_UA) ? bsc_pkg::ISINK_MAX_UA : raw;
  endfunction

  // ----------------------------------------------------------------
  // Bus conditions and live faults
  // ----------------------------------------------------------------
  // Edges use the second and third sync stages only
  assign scl_rise = q.scl[1] & ~q.scl[2];
  assign scl_fall = ~q.scl[1] & q.scl[2];
  assign bus_start = q.scl[1] & q.scl[2] & ~q.sda[1] & q.sda[2];
  assign bus_stop = q.scl[1] & q.scl[2] & q.sda[1] & ~q.sda[2];
  assign conv_on = q.ctrl[bsc_pkg::CTRL_ON_BIT];
  assign unmask = {q.ctrl[bsc_pkg::CTRL_OV_UNMASK_BIT], q.ctrl[bsc_pkg::CTRL_UV_UNMASK_BIT]};

  // Faults count only while regulating; the soft-start ramp would
  // otherwise look like undervoltage. A large code step is not
  // blanked, so it can trip detection.
  assign live = {q.ov[1], q.uv[1]} & {2{conv_on & ~sp_if.ss_active}};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic wr, rd, rd_flt;
    logic [7:0] rdat;
    logic [1:0] clr;
    wr = 1'b0;
    rd = 1'b0;
    rdat = reg_read(q, live);
    rd_flt = 1'b0;
    clr = 2'h0;
    n = q;
    // Two-stage synchronisers; third scl/sda stage feeds edge logic
    n.scl = {q.scl[1:0], I_SCL};
    n.sda = {q.sda[1:0], I_SDA};
    n.uv = {q.uv[0], I_UV_DET};
    n.ov = {q.ov[0], I_OV_DET};
    n.pg = {q.pg[0], I_PG_CMP};
    n.cfg_s1 = I_FACTORY_CONFIG_IMAGE;
    n.cfg_s2 = q.cfg_s1;

    // Straps are caught once, after the synchroniser has filled
    if (q.cap_cnt != 2'h3) begin
      n.cap_cnt = q.cap_cnt + 2'h1;
    end
    if (q.cap_cnt == 2'h2) begin
      n.cfg_cap = q.cfg_s2;
    end

    // I2C byte engine
    if (bus_start) begin
      n.st = bsc_pkg::ST_RX;
      n.bitcnt = 4'h0;
      n.idx = 2'h0;
      n.sda_oe = 1'b0;
    end else if (bus_stop) begin
      n.st = bsc_pkg::ST_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        bsc_pkg::ST_IDLE: begin
          n.sda_oe = 1'b0;
        end
        bsc_pkg::ST_RX: begin
          if (scl_rise) begin
            n.shift = {q.shift[6:0], q.sda[1]};
            n.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == 4'h8) begin
            n.bitcnt = 4'h0;
            n.st = bsc_pkg::ST_ACK;
            n.sda_oe = 1'b1;
            if (q.idx == 2'h0) begin
              n.rw = q.shift[0];
              if (q.shift[7:1] != bsc_pkg::DEV_ADDR) begin
                n.st = bsc_pkg::ST_IDLE;
                n.sda_oe = 1'b0;
              end
            end else if (q.idx == 2'h1) begin
              n.ptr = q.shift;
            end else begin
              wr = 1'b1;
              n.ptr = q.ptr + 8'h01;
            end
          end
        end
        bsc_pkg::ST_ACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            if (q.rw) begin
              rd = 1'b1;
              n.shift = rdat;
              n.ptr = q.ptr + 8'h01;
              n.st = bsc_pkg::ST_TX;
              n.sda_oe = ~rdat[7];
            end else begin
              n.st = bsc_pkg::ST_RX;
              if (q.idx != 2'h2) begin
                n.idx = q.idx + 2'h1;
              end
            end
          end
        end
        bsc_pkg::ST_TX: begin
          if (scl_fall) begin
            if (q.bitcnt == 4'h7) begin
              n.st = bsc_pkg::ST_MACK;
              n.sda_oe = 1'b0;
              n.bitcnt = 4'h0;
            end else begin
              n.shift = {q.shift[6:0], 1'b0};
              n.bitcnt = q.bitcnt + 4'h1;
              n.sda_oe = ~q.shift[6];
            end
          end
        end
        bsc_pkg::ST_MACK: begin
          if (scl_rise) begin
            n.more = ~q.sda[1];
          end else if (scl_fall) begin
            if (q.more) begin
              rd = 1'b1;
              n.shift = rdat;
              n.ptr = q.ptr + 8'h01;
              n.st = bsc_pkg::ST_TX;
              n.sda_oe = ~rdat[7];
            end else begin
              n.st = bsc_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          n.st = bsc_pkg::ST_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
    // Register writes; a new voltage code is the new target at once
    if (wr) begin
      if (q.ptr == bsc_pkg::REG_VCODE) begin
        n.vcode = q.shift[5:0];
      end else if (q.ptr == bsc_pkg::REG_ICODE) begin
        n.icode = q.shift[5:0];
      end else if (q.ptr == bsc_pkg::REG_CTRL) begin
        n.ctrl = q.shift[2:0];
      end
    end
    rd_flt = rd && (q.ptr == bsc_pkg::REG_FAULT);
    // Fault latch: a read clears only a gone fault; a new one wins
    for (int i = 0; i < 2; i++) begin
      n.lat[i] = (q.lat[i] & ~(rd_flt & ~live[i])) | (live[i] & unmask[i]);
      clr[i] = q.rd_seen[i] & (~conv_on | ~live[i]);
      n.pend[i] = (live[i] & unmask[i]) | (q.pend[i] & ~clr[i]);
      n.rd_seen[i] = n.pend[i] & (q.rd_seen[i] | (rd_flt & q.pend[i]));
    end
    n.irq_n = ~|n.pend;
    // Sink is gated by its code alone
    n.sink_en = |q.icode;
    n.sink_ua = sink_ua(q.icode);
    // Power good stays internal; it waits out the soft start
    n.pg_int = conv_on & ~sp_if.ss_active & q.pg[1];
    // Without the dependency, the trigger survives a later disable
    if (q.cfg_cap[bsc_pkg::CFG_SEQ_DEP_BIT]) begin
      n.seq_trig = q.pg_int;
    end else begin
      n.seq_trig = q.seq_trig | q.pg_int;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // Set-point and soft-start timer
  bsc_setpoint #(
    .SS_CYCLES(SS_CYCLES)
  ) u_setpoint (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .sp(sp_if.sp)
  );
  assign sp_if.on = conv_on;
  assign sp_if.vcode = q.vcode;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: only ever pulls low
  assign O_SDA_O = 1'b0;
  assign O_SDA_OE = q.sda_oe;
  assign O_BOOST_EN = conv_on;
  assign O_SS_ACTIVE = sp_if.ss_active;
  assign O_VTARGET_MV = sp_if.target_mv;
  assign O_PG_THRESH_MV = sp_if.pg_mv;
  assign O_ILIM_HI = q.cfg_cap[bsc_pkg::CFG_ILIM_HI_BIT];
  assign O_SINK_EN = q.sink_en;
  assign O_SINK_UA = q.sink_ua;
  assign O_POWER_GOOD_INTERNAL = q.pg_int;
  assign O_SEQ_TRIG = q.seq_trig;
  assign O_INTERRUPT_REQUEST_N = q.irq_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence uv_raised_s;
    live[0] && unmask[0];
  endsequence
  sequence irq_unread_s;
    !O_INTERRUPT_REQUEST_N && q.rd_seen == 2'h0;
  endsequence
  sink_en_a: assert property (q.icode != 6'h00 |=> O_SINK_EN)
    else $error("sink not enabled for non-zero code");
  sink_off_a: assert property (q.icode == 6'h00 |=> !O_SINK_EN)
    else $error("sink enabled for zero code");
  sink_val_a: assert property (##1 O_SINK_UA == 16'd625 * {10'h000, $past(q.icode)})
    else $error("sink current does not match code");
  sink_max_a: assert property (O_SINK_UA <= 16'd39375)
    else $error("sink current above ceiling");
  irq_set_a: assert property (uv_raised_s |=> !O_INTERRUPT_REQUEST_N)
    else $error("unmasked fault did not raise interrupt");
  irq_hold_a: assert property (irq_unread_s |=> !O_INTERRUPT_REQUEST_N)
    else $error("interrupt released before fault read");
  lat_keep_a: assert property (q.lat[1] && live[1] |=> q.lat[1])
    else $error("present fault was cleared");
  masked_live_a: assert property (
    q.st == bsc_pkg::ST_ACK && q.rw && scl_fall && q.ptr == bsc_pkg::REG_FAULT && !unmask[0]
      |=> q.shift[0] == $past(live[0]))
    else $error("masked fault does not show live level");
  pg_off_a: assert property (!conv_on ##1 !conv_on |-> !O_POWER_GOOD_INTERNAL)
    else $error("power good while converter off");
  ilim_fix_a: assert property (q.cap_cnt == 2'h3 |=> $stable(O_ILIM_HI))
    else $error("switch limit changed after capture");
  trig_keep_a: assert property (
    !q.cfg_cap[0] && q.cap_cnt == 2'h3 && O_SEQ_TRIG |=> O_SEQ_TRIG)
    else $error("trigger dropped without dependency");

endmodule
`default_nettype wire

/* File: bsc_host_model.sv */
// Purpose: Host controller model on the register bus, for the bench
// Assumes: SDA pull-up is resolved by the bench from both enables
// Notes: Lines change only just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module bsc_host_model (
  // Clock
  input wire logic i_clk,
  // Bus lines
  input wire logic i_sda,
  output var logic o_scl,
  output var logic o_sda_oe
);
  // Each data-bit SCL high phase lasts 8 clocks (16 in a start), twice the minimum the device needs; data-bit low phases last 10
  localparam int HALF = 8;
  // Idle bus: clock high, data released
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // --------------------------------------------------
  // Bit level
  // --------------------------------------------------
  task automatic half();
    repeat (HALF) @(posedge i_clk);
  endtask
  // Two clocks after SCL falls so SDA never moves near an SCL edge
  task automatic put_bit(input logic b);
    repeat (2) @(posedge i_clk);
    o_sda_oe <= ~b;
    half();
    o_scl <= 1'b1;
    half();
    o_scl <= 1'b0;
  endtask
  // Sampled on a falling edge so the registered answer has settled
  task automatic get_bit(output logic b);
    repeat (2) @(posedge i_clk);
    o_sda_oe <= 1'b0;
    half();
    o_scl <= 1'b1;
    repeat (HALF - 1) @(posedge i_clk);
    @(negedge i_clk);
    b = i_sda;
    @(posedge i_clk);
    o_scl <= 1'b0;
  endtask
  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    o_sda_oe <= 1'b0;
    half();
    o_scl <= 1'b1;
    half();
    o_sda_oe <= 1'b1;
    half();
    o_scl <= 1'b0;
  endtask
  // Stop: SDA rises while SCL is high, then the bus rests
  task automatic stop();
    repeat (2) @(posedge i_clk);
    o_sda_oe <= 1'b1;
    half();
    o_scl <= 1'b1;
    half();
    o_sda_oe <= 1'b0;
    half();
  endtask
  // --------------------------------------------------
  // Bytes and transfers
  // --------------------------------------------------
  task automatic send(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(a);
    ack = (a === 1'b0);
  endtask
  // Last byte is answered with a release, which ends the read
  task automatic recv(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(last);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    send({bsc_pkg::DEV_ADDR, 1'b0}, a0);
    send(p, a1);
    send(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic a;
    start();
    send({bsc_pkg::DEV_ADDR, 1'b0}, a);
    send(p, a);
    start();
    send({bsc_pkg::DEV_ADDR, 1'b1}, a);
    recv(d, 1'b1);
    stop();
  endtask
endmodule
`default_nettype wire

/* File: bsc_top_bench.sv */
// Purpose: Self-checking bench for the boost set-point control
// Assumes: Host model owns the bus; bench drives comparators and straps
// Notes: Soft start shortened to 200 clocks
`timescale 1ns/100ps
`default_nettype none
module bsc_top_bench;
  localparam int unsigned SS = 200;
  logic sys_clk, rst_n, scl, sda, host_oe, uv, ov, pg, ack;
  logic sda_oe, boost_en, ss_act, ilim, sink_en, pwr_good, trig, irq_n;
  logic [1:0] straps;
  logic [14:0] vtgt, pg_mv;
  logic [15:0] sink_ua;
  logic [7:0] rdat;
  logic [5:0] codes [4] = '{6'h00, 6'h07, 6'h38, 6'h3f};
  int n_fail, tests_run;
  // Pull-up: the wire is low while either side pulls
  assign sda = ~(host_oe | sda_oe);
  bsc_top #(.SS_CYCLES(SS)) i_bsc_top (
    .I_SYS_CLK(sys_clk),
    .I_RST_N(rst_n),
    .I_SCL(scl),
    .I_SDA(sda),
    .O_SDA_O(),
    .O_SDA_OE(sda_oe),
    .I_UV_DET(uv),
    .I_OV_DET(ov),
    .I_PG_CMP(pg),
    .I_FACTORY_CONFIG_IMAGE(straps),
    .O_BOOST_EN(boost_en),
    .O_SS_ACTIVE(ss_act),
    .O_VTARGET_MV(vtgt),
    .O_PG_THRESH_MV(pg_mv),
    .O_ILIM_HI(ilim),
    .O_SINK_EN(sink_en),
    .O_SINK_UA(sink_ua),
    .O_POWER_GOOD_INTERNAL(pwr_good),
    .O_SEQ_TRIG(trig),
    .O_INTERRUPT_REQUEST_N(irq_n)
  );
  bsc_host_model i_bsc_host_model (
    .i_clk(sys_clk),
    .i_sda(sda),
    .o_scl(scl),
    .o_sda_oe(host_oe)
  );
  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // --------------------------------------------------
  // Helpers
  // --------------------------------------------------
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_bsc_host_model.wr(p, d, ack);
    chk("ack", 16'(ack), 16'h0001);
  endtask
  task automatic rdchk(input string what, input logic [7:0] p, input logic [7:0] exp);
    i_bsc_host_model.rd(p, rdat);
    chk(what, 16'(rdat), 16'(exp));
  endtask
  // Bounded wait on the interrupt line; running out ends the run
  task automatic wait_irq(input logic lvl);
    for (int k = 0; k < 60 && irq_n !== lvl; k++) begin
      @(negedge sys_clk);
    end
    chk("irq", 16'(irq_n), 16'(lvl));
    if (irq_n !== lvl) begin
      tally_and_finish();
    end
    @(posedge sys_clk);
  endtask
  // Straps are only captured after a reset, so each set needs one
  task automatic do_reset(input logic [1:0] s);
    straps <= s;
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask
  // Cuts a hang short; the whole run stays far below this bound
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    tally_and_finish();
  end
  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    rst_n = 1'b0;
    uv = 1'b0;
    ov = 1'b0;
    pg = 1'b0;
    straps = 2'h2;
    n_fail = 0;
    tests_run = 0;
    do_reset(2'h2);
    chk("vt", 16'(vtgt), 16'h2ee0);
    chk("ilim", 16'(ilim), 16'h0001);
    chk("irq", 16'(irq_n), 16'h0001);
    rdchk("vcode", bsc_pkg::REG_VCODE, 8'h1c);
    rdchk("icode", bsc_pkg::REG_ICODE, 8'h00);
    // Code extremes and both halves of the voltage code
    for (int i = 0; i < 4; i++) begin
      wr(bsc_pkg::REG_VCODE, {2'h0, codes[i]});
      wr(bsc_pkg::REG_ICODE, {2'h0, codes[i]});
      chk("vt", 16'(vtgt), 16'(32'h1388 + 32'hfa * codes[i]));
      chk("pg", 16'(pg_mv), 16'((32'h1388 + 32'hfa * codes[i]) * 32'h7 / 32'ha));
      chk("ua", sink_ua, 16'(32'h271 * codes[i]));
      chk("sink", 16'(sink_en), 16'(codes[i] != 6'h00));
      chk("en", 16'(boost_en), 16'h0000);
      rdchk("vcode", bsc_pkg::REG_VCODE, {2'h0, codes[i]});
      rdchk("icode", bsc_pkg::REG_ICODE, {2'h0, codes[i]});
    end
    wr(bsc_pkg::REG_VCODE, 8'h1c);
    pg <= 1'b1;
    wr(bsc_pkg::REG_CTRL, 8'h01);
    chk("en", 16'(boost_en), 16'h0001);
    chk("sink", 16'(sink_en), 16'h0001);
    chk("ss", 16'(ss_act), 16'h0001);
    chk("pgood", 16'(pwr_good), 16'h0000);
    repeat (SS) @(posedge sys_clk);
    chk("ss", 16'(ss_act), 16'h0000);
    chk("pgood", 16'(pwr_good), 16'h0001);
    chk("trig", 16'(trig), 16'h0001);
    wr(bsc_pkg::REG_ICODE, 8'h00);
    chk("sink", 16'(sink_en), 16'h0000);
    chk("en", 16'(boost_en), 16'h0001);
    // Modest step while running: new target at once, no fresh ramp
    wr(bsc_pkg::REG_VCODE, 8'h1e);
    chk("vt", 16'(vtgt), 16'h30d4);
    chk("ss", 16'(ss_act), 16'h0000);
    // Masked faults read live and never interrupt
    uv <= 1'b1;
    rdchk("flt", bsc_pkg::REG_FAULT, 8'h01);
    chk("irq", 16'(irq_n), 16'h0001);
    uv <= 1'b0;
    rdchk("flt", bsc_pkg::REG_FAULT, 8'h00);
    // Unmasked: latch survives a read while the fault persists
    wr(bsc_pkg::REG_CTRL, 8'h07);
    ov <= 1'b1;
    wait_irq(1'b0);
    rdchk("flt", bsc_pkg::REG_FAULT, 8'h02);
    rdchk("flt", bsc_pkg::REG_FAULT, 8'h02);
    chk("irq", 16'(irq_n), 16'h0000);
    ov <= 1'b0;
    rdchk("flt", bsc_pkg::REG_FAULT, 8'h02);
    wait_irq(1'b1);
    rdchk("flt", bsc_pkg::REG_FAULT, 8'h00);
    // A short fault still holds the interrupt until read
    uv <= 1'b1;
    wait_irq(1'b0);
    uv <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk("irq", 16'(irq_n), 16'h0000);
    rdchk("flt", bsc_pkg::REG_FAULT, 8'h01);
    wait_irq(1'b1);
    // Switching off with the fault present, then reading, releases it
    ov <= 1'b1;
    wait_irq(1'b0);
    wr(bsc_pkg::REG_CTRL, 8'h06);
    chk("irq", 16'(irq_n), 16'h0000);
    rdchk("flt", bsc_pkg::REG_FAULT, 8'h02);
    wait_irq(1'b1);
    chk("trig", 16'(trig), 16'h0001);
    ov <= 1'b0;
    // Foreign address is not answered; an empty pointer reads zero
    i_bsc_host_model.start();
    i_bsc_host_model.send({bsc_pkg::DEV_ADDR ^ 7'h01, 1'b0}, ack);
    i_bsc_host_model.stop();
    chk("nack", 16'(ack), 16'h0000);
    rdchk("none", 8'h07, 8'h00);
    // Second strap set: disable now drops the downstream trigger
    do_reset(2'h1);
    chk("ilim", 16'(ilim), 16'h0000);
    wr(bsc_pkg::REG_CTRL, 8'h01);
    repeat (SS) @(posedge sys_clk);
    chk("trig", 16'(trig), 16'h0001);
    wr(bsc_pkg::REG_CTRL, 8'h00);
    chk("trig", 16'(trig), 16'h0000);
    chk("pgood", 16'(pwr_good), 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
